// ### ctsi_defines.svh
`ifndef CTSI_DEFINES_SVH
`define CTSI_DEFINES_SVH

// Clock and tick timing
`define CTSI_CLK_HZ          200000000
`define CTSI_TICK_PERIOD_S   1
`define CTSI_TICK_CYCLES     (`CTSI_CLK_HZ * `CTSI_TICK_PERIOD_S)
// Default arming delay in whole seconds
`define CTSI_ARM_SECONDS     10
// Display page codes
`define CTSI_PAGE_NOW_TIME   2'h0
`define CTSI_PAGE_NOW_DATE   2'h1
`define CTSI_PAGE_FIRST_TIME 2'h2
`define CTSI_PAGE_FIRST_DATE 2'h3
// Calendar field widths
`define CTSI_FIELD_W         6
`define CTSI_YEAR_W          7

`endif

// ### ctsi_pkg.sv
package ctsi_pkg;

  // Time of day, binary fields
  typedef struct packed {
    logic [5:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } ctsi_time_t;

  // Calendar date, binary fields
  typedef struct packed {
    logic [6:0] year;
    logic [5:0] month;
    logic [5:0] day;
  } ctsi_date_t;

  typedef struct packed {
    ctsi_date_t date;
    ctsi_time_t time_of_day;
  } ctsi_stamp_t;

  // Label shown on the upper display line
  typedef enum logic [1:0] {
    CTSI_LBL_NOW_TIME   = 2'b00,
    CTSI_LBL_NOW_DATE   = 2'b01,
    CTSI_LBL_FIRST_TIME = 2'b10,
    CTSI_LBL_FIRST_DATE = 2'b11
  } ctsi_label_t;

  // Arming state
  typedef enum logic [0:0] {
    CTSI_ARMING = 1'b0,
    CTSI_ARMED  = 1'b1
  } ctsi_arm_t;

  // Status display contents
  typedef struct packed {
    ctsi_label_t label;        // Upper line
    logic        value_none;   // Lower line reads "None"
    logic        value_is_date;
    logic [18:0] value;        // Lower line value bits
    logic        clock_icon;
    logic        boxed_r_icon;
    logic        case_open_sym;
    logic        backup_sym;
  } ctsi_disp_t;

endpackage

// ### ctsi_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for pin levels
module ctsi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // First stage read only by the second
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ### ctsi_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctsi_defines.svh"

// Notes on behaviour
// [R01] Live lamp lit while case open, on primary supply, after arming delay.
// [R02] Live lamp follows the case state; it never latches.
// [R03] Latched lamp lights on any armed case-open event on primary supply.
// [R04] Latched lamp stays lit after closing; only reset clears it.
// [R05] Arming lamp toggles every second until the arming delay ends.
// [R06] After arming the arming lamp goes off and stays off.
// [R07] Date and time of first tamper event are stored for display.
// [R08] Label goes on the upper line, value on the lower line.
// [R09] Present time or date pages turn on the clock icon.
// [R10] First-event time or date pages turn on the boxed-R icon instead.
// [R11] With no first event recorded, first-event pages read None.
// [R12] Case-open symbol while open; backup symbol while on backup supply.
// [R13] Clear button erases the stored first event for re-recording.
// [R14] Arming delay is a parameter in seconds; events ignored until expiry.
module ctsi_top
  import ctsi_pkg::*;
#(
  parameter int ARM_SECONDS = `CTSI_ARM_SECONDS,
  parameter int TICK_CYCLES = `CTSI_TICK_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        case_open_in,
  input  wire logic        backup_supply_in,
  input  wire logic        clear_first_event_button_in,
  input  wire ctsi_stamp_t now_stamp_in,
  input  wire logic [1:0]  page_sel_in,
  output var  logic        live_tamper_lamp_out,
  output var  logic        latched_tamper_lamp_out,
  output var  logic        arming_indicator_lamp_out,
  output var  logic        armed_out,
  output var  logic        second_tick_out,
  output var  ctsi_disp_t  disp_out
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (ARM_SECONDS < 1 || ARM_SECONDS > 65535) begin : g_bad_arm
    $error("ARM_SECONDS out of range");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int AW = $clog2(ARM_SECONDS + 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pins_s;

  ctsi_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   ({clear_first_event_button_in, backup_supply_in, case_open_in}),
    .sync_out   (pins_s)
  );

  logic case_open_s;
  logic backup_s;
  logic clear_btn_s;
  assign case_open_s = pins_s[0];
  assign backup_s    = pins_s[1];
  assign clear_btn_s = pins_s[2];

  // Page select is on the same clock, used directly
  function automatic ctsi_label_t page_to_label(input logic [1:0] sel);
    case (sel)
      `CTSI_PAGE_NOW_TIME:   page_to_label = CTSI_LBL_NOW_TIME;
      `CTSI_PAGE_NOW_DATE:   page_to_label = CTSI_LBL_NOW_DATE;
      `CTSI_PAGE_FIRST_TIME: page_to_label = CTSI_LBL_FIRST_TIME;
      default:               page_to_label = CTSI_LBL_FIRST_DATE;
    endcase
  endfunction

  function automatic logic is_first_page(input ctsi_label_t lbl);
    is_first_page = (lbl == CTSI_LBL_FIRST_TIME) || (lbl == CTSI_LBL_FIRST_DATE);
  endfunction

  // ****************************************
  // One-second tick
  // ****************************************
  logic [TW-1:0] tick_cnt_r;
  logic          tick_nxt;

  assign tick_nxt = (tick_cnt_r == TW'(TICK_CYCLES - 1));

  // Free running divider from reset
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_r <= '0;
    end else if (tick_nxt) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      second_tick_out <= 1'b0;
    end else begin
      second_tick_out <= tick_nxt;
    end
  end

  // ****************************************
  // Arming delay
  // ****************************************
  ctsi_arm_t     arm_state_r;
  logic [AW-1:0] arm_secs_r;

  // Seconds counted from reset; a long delay simply holds events off longer
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      arm_state_r <= CTSI_ARMING;
      arm_secs_r  <= '0;
    end else begin
      case (arm_state_r)
        CTSI_ARMING: begin
          if (tick_nxt) begin
            if (arm_secs_r == AW'(ARM_SECONDS - 1)) begin
              arm_state_r <= CTSI_ARMED; // [R14]
            end
            arm_secs_r <= arm_secs_r + AW'(1);
          end
        end
        CTSI_ARMED: begin
          arm_state_r <= CTSI_ARMED;
        end
        default: begin
          arm_state_r <= CTSI_ARMING;
        end
      endcase
    end
  end

  logic armed;
  assign armed = (arm_state_r == CTSI_ARMED);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      armed_out <= 1'b0;
    end else begin
      armed_out <= armed;
    end
  end

  // Arming lamp blinks each second, then dark for good
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      arming_indicator_lamp_out <= 1'b0;
    end else if (armed) begin
      arming_indicator_lamp_out <= 1'b0; // [R06]
    end else if (tick_nxt) begin
      arming_indicator_lamp_out <= ~arming_indicator_lamp_out; // [R05]
    end
  end

  // ****************************************
  // Tamper lamps
  // ****************************************
  logic tamper_evt;
  assign tamper_evt = armed && !backup_s && case_open_s; // [R14]

  // Live lamp tracks the case, no memory
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      live_tamper_lamp_out <= 1'b0;
    end else begin
      live_tamper_lamp_out <= tamper_evt; // [R01] [R02]
    end
  end

  // Sticky until reset; the clear button does not touch it
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      latched_tamper_lamp_out <= 1'b0; // [R04]
    end else if (tamper_evt) begin
      latched_tamper_lamp_out <= 1'b1; // [R03]
    end
  end

  // ****************************************
  // First event record
  // ****************************************
  ctsi_stamp_t first_stamp_r;
  logic        first_valid_r;
  logic        evt_d_r;
  logic        evt_rise;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      evt_d_r <= 1'b0;
    end else begin
      evt_d_r <= tamper_evt;
    end
  end

  // Capture on open edge, so a case held open after a clear is not recorded
  assign evt_rise = tamper_evt && !evt_d_r;

  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      first_valid_r <= 1'b0;
      first_stamp_r <= '0;
    end else if (evt_rise && (!first_valid_r || clear_btn_s)) begin
      first_valid_r <= 1'b1; // [R07]
      first_stamp_r <= now_stamp_in; // [R07]
    end else if (clear_btn_s) begin
      first_valid_r <= 1'b0; // [R13]
    end
  end

  // ****************************************
  // Status display
  // ****************************************
  ctsi_disp_t  disp_nxt;
  ctsi_label_t lbl;
  logic        first_pg;
  ctsi_stamp_t src;

  always_comb begin
    lbl      = page_to_label(page_sel_in);
    first_pg = is_first_page(lbl);
    src      = first_pg ? first_stamp_r : now_stamp_in;
    disp_nxt = '0;
    disp_nxt.label         = lbl; // [R08]
    disp_nxt.value_is_date = (lbl == CTSI_LBL_NOW_DATE) || (lbl == CTSI_LBL_FIRST_DATE);
    disp_nxt.value         = disp_nxt.value_is_date ? src.date : {1'b0, src.time_of_day}; // [R08]
    disp_nxt.clock_icon    = !first_pg; // [R09]
    disp_nxt.boxed_r_icon  = first_pg; // [R10]
    if (first_pg && !first_valid_r) begin
      disp_nxt.value_none = 1'b1; // [R11]
      disp_nxt.value      = '0;
    end
    disp_nxt.case_open_sym = case_open_s; // [R12]
    disp_nxt.backup_sym    = backup_s; // [R12]
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      disp_out <= '0;
    end else begin
      disp_out <= disp_nxt;
    end
  end

endmodule

`default_nettype wire

// ### ctsi_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctsi_defines.svh"
// ****
// Checker
// ****
module ctsi_top_chk
  import ctsi_pkg::*;
#(
  parameter int ARM_SECONDS = `CTSI_ARM_SECONDS,
  parameter int TICK_CYCLES = `CTSI_TICK_CYCLES
) (
  input wire logic       clk_sys_in,
  input wire logic       rst_in,
  input wire logic       case_open_in,
  input wire logic [1:0] page_sel_in,
  input wire logic       live_tamper_lamp_out,
  input wire logic       latched_tamper_lamp_out,
  input wire logic       arming_indicator_lamp_out,
  input wire logic       armed_out,
  input wire logic       second_tick_out,
  input wire ctsi_disp_t disp_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // Helper counters: cycles since the last tick, ticks since reset
  int gap_r;
  int ticks_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      gap_r   <= 0;
      ticks_r <= 0;
    end else if (second_tick_out) begin
      gap_r   <= 0;
      ticks_r <= ticks_r + 1;
    end else begin
      gap_r <= gap_r + 1;
    end
  end

  // Pin seen closed or open through the full sync path
  sequence s_closed;
    !case_open_in [*3];
  endsequence
  sequence s_open;
    case_open_in [*4];
  endsequence
  a_live_armed: assert property (live_tamper_lamp_out |-> armed_out) else $error("live lamp before arming");
  a_live_follow: assert property (s_closed |=> !live_tamper_lamp_out) else $error("live lamp latched");
  a_latch_live: assert property (live_tamper_lamp_out |-> latched_tamper_lamp_out) else $error("latch missed");
  a_latch_hold: assert property (latched_tamper_lamp_out |=> latched_tamper_lamp_out) else $error("latch lost");
  a_arm_off: assert property (armed_out |-> !arming_indicator_lamp_out) else $error("arm lamp lit");
  a_arm_stay: assert property (armed_out |=> armed_out) else $error("armed dropped");
  a_arm_toggle: assert property (second_tick_out && !armed_out
    |-> arming_indicator_lamp_out != $past(arming_indicator_lamp_out)) else $error("no toggle");
  a_arm_steady: assert property (!second_tick_out && !armed_out
    |-> $stable(arming_indicator_lamp_out)) else $error("stray toggle");
  a_tick_gap: assert property (second_tick_out |=> !second_tick_out [*8]) else $error("tick gap");
  a_tick_space: assert property (second_tick_out && ticks_r != 0
    |-> gap_r == TICK_CYCLES - 1) else $error("tick spacing wrong");
  a_arm_count: assert property ($rose(armed_out) |-> ticks_r == ARM_SECONDS) else $error("arming length wrong");
  // Reset value of the display is all zero, so the first edge after release is skipped
  a_icon_pick: assert property (!$past(rst_in) |-> disp_out.clock_icon == !disp_out.label[1]
    && disp_out.boxed_r_icon == disp_out.label[1]) else $error("icon wrong");
  a_label_page: assert property (1'b1 |=> disp_out.label == $past(page_sel_in)) else $error("label wrong");
  a_none_zero: assert property (disp_out.value_none |-> disp_out.value == 19'h0 && disp_out.label[1])
    else $error("none wrong");
  a_open_sym: assert property (s_open |-> disp_out.case_open_sym) else $error("open symbol off");
endmodule
bind ctsi_top ctsi_top_chk #(.ARM_SECONDS(ARM_SECONDS), .TICK_CYCLES(TICK_CYCLES)) ctsi_top_chk_i (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .case_open_in(case_open_in), .page_sel_in(page_sel_in),
  .live_tamper_lamp_out(live_tamper_lamp_out), .latched_tamper_lamp_out(latched_tamper_lamp_out),
  .arming_indicator_lamp_out(arming_indicator_lamp_out), .armed_out(armed_out),
  .second_tick_out(second_tick_out), .disp_out(disp_out));
`default_nettype wire

// ### ctsi_case_switch.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Inductive case switch
// ****
module ctsi_case_switch (
  input  wire logic clk_sys_in,
  input  wire logic open_cmd_in,
  output var  logic case_open_out
);
  // Sensor output moves on the rising edge of clk_sys_in, away from the bench's falling-edge strobe
  always_ff @(posedge clk_sys_in) begin
    case_open_out <= open_cmd_in;
  end
endmodule
`default_nettype wire

// ### tb_ctsi_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Bench
// ****
module tb_ctsi_top
  import ctsi_pkg::*;
;
  localparam int ARM = 2;
  localparam int TICK = 10;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        open_cmd = 1'b0;
  logic        backup = 1'b0;
  logic        clr = 1'b0;
  logic [1:0]  page = 2'h0;
  ctsi_stamp_t stamp = '0;
  wire logic   case_open;
  logic        live, latched, arm_lamp, armed, tick;
  ctsi_disp_t  disp;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  ctsi_case_switch ctsi_case_switch_i (.clk_sys_in(clk_sys_in), .open_cmd_in(open_cmd), .case_open_out(case_open));
  ctsi_top #(.ARM_SECONDS(ARM), .TICK_CYCLES(TICK)) ctsi_top_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .case_open_in(case_open), .backup_supply_in(backup),
    .clear_first_event_button_in(clr), .now_stamp_in(stamp), .page_sel_in(page),
    .live_tamper_lamp_out(live), .latched_tamper_lamp_out(latched), .arming_indicator_lamp_out(arm_lamp),
    .armed_out(armed), .second_tick_out(tick), .disp_out(disp));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  // Hang guard, well beyond the hundred or so cycles needed
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end
  task conclude;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string what, input logic [18:0] exp, input logic [18:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", what, exp, got);
    end
  endtask
  task wc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // Opening during arming must leave no trace
  task t_arming;
    int k;
    int n;
    n = 0;
    open_cmd = 1'b1;
    wc(8);
    open_cmd = 1'b0;
    for (k = 0; k < 100 && armed !== 1'b1; k++) begin
      wc(1);
      if (tick === 1'b1) n++;
    end
    chk("ticks", 19'(ARM), 19'(n));
    wc(12);
    chk("latched", 19'h0, 19'(latched));
    chk("arm lamp", 19'h0, 19'(arm_lamp));
  endtask
  // Every page with a known present stamp
  task t_pages;
    int p;
    stamp = {7'h11, 6'h06, 6'h14, 6'h08, 6'h2d, 6'h1e};
    for (p = 0; p < 4; p++) begin
      page = 2'(p);
      wc(2);
      chk("label", 19'(p), 19'(disp.label));
      chk("is date", 19'(p[0]), 19'(disp.value_is_date));
      chk("clock", 19'(p < 2), 19'(disp.clock_icon));
      chk("boxed", 19'(p > 1), 19'(disp.boxed_r_icon));
      chk("none", 19'(p > 1), 19'(disp.value_none));
      if (p == 0) chk("now time", {1'b0, stamp.time_of_day}, disp.value);
      if (p == 1) chk("now date", stamp.date, disp.value);
      if (p > 1) chk("none value", 19'h0, disp.value);
    end
  endtask
  // Backup supply blocks tamper capture; it outlasts the opening, since the
  // case path is one cycle slower and an early release would latch an event
  task t_backup;
    backup = 1'b1;
    open_cmd = 1'b1;
    wc(6);
    chk("live", 19'h0, 19'(live));
    chk("latched", 19'h0, 19'(latched));
    chk("backup sym", 19'h1, 19'(disp.backup_sym));
    chk("open sym", 19'h1, 19'(disp.case_open_sym));
    open_cmd = 1'b0;
    wc(6);
    chk("open sym", 19'h0, 19'(disp.case_open_sym));
    backup = 1'b0;
    wc(6);
    chk("backup sym", 19'h0, 19'(disp.backup_sym));
    chk("latched", 19'h0, 19'(latched));
  endtask
  task t_event(input ctsi_stamp_t s);
    stamp = s;
    open_cmd = 1'b1;
    page = 2'h2;
    wc(6);
    stamp = ~s;
    chk("live", 19'h1, 19'(live));
    chk("latched", 19'h1, 19'(latched));
    chk("first time", {1'b0, s.time_of_day}, disp.value);
    page = 2'h3;
    wc(2);
    chk("first date", s.date, disp.value);
    open_cmd = 1'b0;
    wc(6);
    chk("live", 19'h0, 19'(live));
    chk("latched", 19'h1, 19'(latched));
  endtask
  // Clear then record a new first event
  task t_clear;
    clr = 1'b1;
    wc(5);
    clr = 1'b0;
    page = 2'h2;
    wc(2);
    chk("none", 19'h1, 19'(disp.value_none));
    t_event({7'h2a, 6'h0b, 6'h1f, 6'h17, 6'h3b, 6'h01});
  endtask
  // A reset clears the latched lamp and the first-event record
  task t_reset;
    page = 2'h2;
    rst_in = 1'b1;
    wc(5);
    rst_in = 1'b0;
    wc(2);
    chk("latched", 19'h0, 19'(latched));
    chk("armed", 19'h0, 19'(armed));
    chk("none", 19'h1, 19'(disp.value_none));
    chk("boxed", 19'h1, 19'(disp.boxed_r_icon));
  endtask
  initial begin
    wc(5);
    rst_in = 1'b0;
    t_arming();
    t_pages();
    t_backup();
    t_event({7'h15, 6'h03, 6'h09, 6'h0c, 6'h22, 6'h05});
    t_clear();
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
